/* opm_ctrl.sv */
// The placing of the registers and register access over APB were chosen for this implementation.
module opm_ctrl #(
  parameter int XTAL_WAKE_CYC = opm_pkg::OPM_XTAL_WAKE_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic [7:0] port_a_pin,
  input wire logic [7:0] port_a_wake_en,
  input wire logic sys_irq,
  input wire logic wdt_overflow,
  input wire logic slow_rc_ready,
  output logic cpu_stall,
  output logic pc_sp_reset,
  output logic wdt_clear,
  output logic fast_clk_on,
  output logic slow_clk_on,
  output logic sys_clk_gate,
  output logic sys_clk_is_slow,
  output logic [6:0] sys_clk_div,
  output logic xtal_osc_run,
  output logic frc_osc_run,
  output logic [7:0] frc_trim,
  output logic power_down_flag,
  output logic watchdog_timeout_flag
);
  // ***************************************************************
  // Register bus
  // ***************************************************************
  // The slave never stretches a transfer: pready is tied high, so a write
  // lands at the edge that closes the access phase and a read is served
  // straight from the register outputs through the mux below.
  logic wr_en;
  logic rd_hit;
  logic [2:0] sel_q;
  logic keep_fast_q;
  logic keep_slow_q;
  logic fast_src_q;
  logic xtal_en_q;
  logic frc_en_q;
  logic [7:0] trim_q;
  logic xtal_stable_q;
  logic frc_stable_q;
  logic slow_mode_q;
  // Start-up counters, wide enough for the crystal count
  logic [10:0] xtal_cnt_q;
  logic [4:0] frc_cnt_q;
  // Input synchronisers
  logic [1:0] pa_s1_q;
  logic [1:0] pa_s2_q;
  logic [1:0] pa_s3_q;
  logic [7:0] pa_sync1_q;
  logic [7:0] pa_sync2_q;
  logic [7:0] pa_sync3_q;
  logic [7:0] pa_stable_q;
  // Power-down state and wake bookkeeping
  opm_pkg::opm_state_t state_q;
  logic [10:0] wake_cnt_q;
  logic wake_by_wdt_q;
  logic fast_kept_q;
  opm_pkg::opm_wake_t wake;
  logic fast_stable;
  logic halted;
  logic [10:0] wake_len;

  // Zero-wait slave; every access finishes in the access cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_hit = (paddr == opm_pkg::OPM_ADDR_SYSCLK_CFG) ||
                  (paddr == opm_pkg::OPM_ADDR_XTAL_CTRL) ||
                  (paddr == opm_pkg::OPM_ADDR_FRC_CTRL) ||
                  (paddr == opm_pkg::OPM_ADDR_FRC_TRIM) ||
                  (paddr == opm_pkg::OPM_ADDR_STATUS);
  assign pslverr = psel && penable && !rd_hit;

  // Read mux; unused bits read zero
  // Bits with no storage behind them are left at the zero default, so
  // software sees 0 there whatever it wrote earlier.
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      opm_pkg::OPM_ADDR_SYSCLK_CFG: begin
        prdata[opm_pkg::OPM_POS_SEL +: 3] = sel_q;
        prdata[opm_pkg::OPM_BIT_FAST_SRC] = fast_src_q;
        prdata[opm_pkg::OPM_BIT_KEEP_FAST] = keep_fast_q;
        prdata[opm_pkg::OPM_BIT_KEEP_SLOW] = keep_slow_q;
      end
      opm_pkg::OPM_ADDR_XTAL_CTRL: begin
        prdata[opm_pkg::OPM_BIT_STABLE] = xtal_stable_q;
        prdata[opm_pkg::OPM_BIT_EN] = xtal_en_q;
      end
      opm_pkg::OPM_ADDR_FRC_CTRL: begin
        prdata[opm_pkg::OPM_BIT_STABLE] = frc_stable_q;
        prdata[opm_pkg::OPM_BIT_EN] = frc_en_q;
      end
      opm_pkg::OPM_ADDR_FRC_TRIM: begin
        prdata[7:0] = trim_q;
      end
      opm_pkg::OPM_ADDR_STATUS: begin
        prdata[0] = power_down_flag;
        prdata[1] = watchdog_timeout_flag;
        prdata[2] = slow_mode_q;
        prdata[3] = halted;
      end
      default: begin
        prdata = 32'h0000_0000;
      end
    endcase
  end

  // Clock configuration register
  // The select field is taken as written; the mode itself only follows
  // once the target source reports stable, see the run mode section.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q <= opm_pkg::OPM_SEL_RST;
      keep_fast_q <= 1'b0;
      keep_slow_q <= 1'b0;
      fast_src_q <= 1'b0;
    end else if (wr_en && paddr == opm_pkg::OPM_ADDR_SYSCLK_CFG) begin
      sel_q <= pwdata[opm_pkg::OPM_POS_SEL +: 3];
      keep_fast_q <= pwdata[opm_pkg::OPM_BIT_KEEP_FAST];
      keep_slow_q <= pwdata[opm_pkg::OPM_BIT_KEEP_SLOW];
      fast_src_q <= pwdata[opm_pkg::OPM_BIT_FAST_SRC];
    end
  end

  // Oscillator enables; only bit 0 is writable
  // A write to bit 1 is dropped: the stable flags belong to the counters.
  // Trim is kept as a plain byte and handed to the fast RC as is.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      xtal_en_q <= opm_pkg::OPM_XTAL_EN_RST;
      frc_en_q <= opm_pkg::OPM_FRC_EN_RST;
      trim_q <= opm_pkg::OPM_TRIM_RST;
    end else if (wr_en) begin
      if (paddr == opm_pkg::OPM_ADDR_XTAL_CTRL) begin
        xtal_en_q <= pwdata[opm_pkg::OPM_BIT_EN];
      end
      if (paddr == opm_pkg::OPM_ADDR_FRC_CTRL) begin
        frc_en_q <= pwdata[opm_pkg::OPM_BIT_EN];
      end
      if (paddr == opm_pkg::OPM_ADDR_FRC_TRIM) begin
        trim_q <= pwdata[7:0];
      end
    end
  end

  // ***************************************************************
  // Oscillator start-up counters
  // ***************************************************************
  // Both oscillators are modelled by counting core clocks from the moment
  // they start. A stopped oscillator also loses its stable flag, so a
  // later restart always waits out the full start-up count.
  // Oscillator runs when enabled and not stopped by the power mode
  assign xtal_osc_run = xtal_en_q && fast_clk_on;
  assign frc_osc_run = frc_en_q && fast_clk_on;
  assign frc_trim = trim_q;

  // Crystal counter restarts on every enable write of 1 or stop
  // Writing 1 again while already running restarts the count as well;
  // software then sees the flag drop before it rises once more.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      xtal_cnt_q <= 11'h000;
      xtal_stable_q <= 1'b0;
    end else if (!xtal_osc_run ||
                 (wr_en && paddr == opm_pkg::OPM_ADDR_XTAL_CTRL &&
                  pwdata[opm_pkg::OPM_BIT_EN])) begin
      xtal_cnt_q <= 11'h000;
      xtal_stable_q <= 1'b0;
    end else if (xtal_cnt_q == 11'(XTAL_WAKE_CYC - 1)) begin
      xtal_stable_q <= 1'b1;
    end else begin
      xtal_cnt_q <= xtal_cnt_q + 11'h001;
    end
  end

  // Fast RC counter also restarts on a frequency change
  // Rewriting the same trim value is not a frequency change and leaves
  // the flag alone; only a real change, a fresh enable or a stop restarts it.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      frc_cnt_q <= 5'h00;
      frc_stable_q <= 1'b0;
    end else if (!frc_osc_run ||
                 (wr_en && paddr == opm_pkg::OPM_ADDR_FRC_TRIM &&
                  pwdata[7:0] != trim_q) ||
                 (wr_en && paddr == opm_pkg::OPM_ADDR_FRC_CTRL &&
                  pwdata[opm_pkg::OPM_BIT_EN] && !frc_en_q)) begin
      frc_cnt_q <= 5'h00;
      frc_stable_q <= 1'b0;
    end else if (frc_cnt_q == 5'(opm_pkg::OPM_FRC_WAKE_CYC - 1)) begin
      frc_stable_q <= 1'b1;
    end else begin
      frc_cnt_q <= frc_cnt_q + 5'h01;
    end
  end

  // Stable flag of whichever fast source the config selects
  assign fast_stable = fast_src_q ? xtal_stable_q : frc_stable_q;

  // ***************************************************************
  // Run mode switching
  // ***************************************************************
  // Mode follows select only once the target clock is stable
  // Holding the old mode until the new source is stable avoids running
  // the core on a clock that has not settled yet. A select written back
  // before the switch completes simply cancels it.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_mode_q <= 1'b0;
    end else if (sel_q == opm_pkg::OPM_SEL_SLOW && slow_rc_ready) begin
      slow_mode_q <= 1'b1;
    end else if (sel_q != opm_pkg::OPM_SEL_SLOW && fast_stable) begin
      slow_mode_q <= 1'b0;
    end
  end

  // Divider ratio as one-hot of the power of two
  // The ratio is frozen while slow mode is active, so the fast divider
  // only moves once the fast source has taken over again.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_clk_div <= 7'h01;
    end else if (!slow_mode_q && sel_q != opm_pkg::OPM_SEL_SLOW) begin
      sys_clk_div <= 7'(7'h01 << sel_q);
    end
  end
  assign sys_clk_is_slow = slow_mode_q;

  // ***************************************************************
  // Wake-up sources
  // ***************************************************************
  // Port pins pass three flops; a change counts when two agree
  // Requiring two flops to agree filters a single-cycle glitch; the cost
  // is a detection latency of about four core clocks.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pa_sync1_q <= 8'hff;
      pa_sync2_q <= 8'hff;
      pa_sync3_q <= 8'hff;
      pa_stable_q <= 8'hff;
    end else begin
      pa_sync1_q <= port_a_pin;
      pa_sync2_q <= pa_sync1_q;
      pa_sync3_q <= pa_sync2_q;
      pa_stable_q <= (pa_sync2_q & pa_sync3_q) |
                     (pa_stable_q & (pa_sync2_q | pa_sync3_q));
    end
  end
  // Async irq and overflow levels pass three flops; a level counts once two agree
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pa_s1_q <= 2'h0;
      pa_s2_q <= 2'h0;
      pa_s3_q <= 2'h0;
    end else begin
      pa_s1_q <= {sys_irq, wdt_overflow};
      pa_s2_q <= pa_s1_q;
      pa_s3_q <= pa_s2_q;
    end
  end
  assign wake.port_fall = |(pa_stable_q & ~pa_sync2_q & ~pa_sync3_q &
                            port_a_wake_en);
  assign wake.irq = pa_s2_q[1] && pa_s3_q[1];
  assign wake.wdt_ovf = pa_s2_q[0] && pa_s3_q[0];

  // ***************************************************************
  // Power-down state machine
  // ***************************************************************
  // The machine leaves run only on a halt, and leaves a halt state only
  // through the wake state, where the restart delay is counted.
  assign halted = state_q != opm_pkg::OPM_RUN;
  // Longer delay only when the fast source was stopped; whether it ran is
  // latched on leaving the halt state, since that state is gone meanwhile
  assign wake_len = (slow_mode_q || fast_kept_q) ? 11'(opm_pkg::OPM_RUN_WAKE_CYC) :
                    fast_src_q ? 11'(XTAL_WAKE_CYC) :
                    11'(opm_pkg::OPM_FRC_WAKE_CYC);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= opm_pkg::OPM_RUN;
      wake_cnt_q <= 11'h000;
      wake_by_wdt_q <= 1'b0;
      fast_kept_q <= 1'b0;
    end else begin
      case (state_q)
        opm_pkg::OPM_RUN: begin
          wake_by_wdt_q <= 1'b0;
          if (halt_exec) begin
            case ({keep_fast_q, keep_slow_q})
              2'b00: state_q <= opm_pkg::OPM_SLEEP;
              2'b01: state_q <= opm_pkg::OPM_IDLE_SLOW;
              2'b11: state_q <= opm_pkg::OPM_IDLE_BOTH;
              default: state_q <= opm_pkg::OPM_IDLE_FAST;
            endcase
          end
        end
        opm_pkg::OPM_SLEEP, opm_pkg::OPM_IDLE_SLOW,
        opm_pkg::OPM_IDLE_BOTH, opm_pkg::OPM_IDLE_FAST: begin
          // The wake counter is held at zero so every wake starts a fresh count
          wake_cnt_q <= 11'h000;
          if (wake.port_fall || wake.irq || wake.wdt_ovf) begin
            state_q <= opm_pkg::OPM_WAKE;
            wake_by_wdt_q <= wake.wdt_ovf;
            fast_kept_q <= fast_clk_on;
          end
        end
        opm_pkg::OPM_WAKE: begin
          wake_cnt_q <= wake_cnt_q + 11'h001;
          // Hold the CPU until delay done and, outside slow mode, fast clock stable
          if (wake_cnt_q >= wake_len - 11'h001 &&
              (slow_mode_q || fast_stable)) begin
            state_q <= opm_pkg::OPM_RUN;
          end
        end
        default: state_q <= opm_pkg::OPM_RUN;
      endcase
    end
  end

  // Clock gating per mode; registers simply hold meanwhile
  assign fast_clk_on = !(state_q == opm_pkg::OPM_SLEEP ||
                         state_q == opm_pkg::OPM_IDLE_SLOW);
  // These are enables for the clock gates outside, decoded from registered
  // state, so they change only just after a clock edge.
  // Slow RC feeds the watchdog, so it only stops in fast-only idle
  assign slow_clk_on = state_q != opm_pkg::OPM_IDLE_FAST;
  // CPU clock stops in every halt state; system clock kept in fast idle only outside slow mode
  assign cpu_stall = halted;
  assign sys_clk_gate = (state_q == opm_pkg::OPM_RUN) ||
                        (state_q == opm_pkg::OPM_IDLE_BOTH) ||
                        (state_q == opm_pkg::OPM_IDLE_FAST &&
                         !slow_mode_q) ||
                        (state_q == opm_pkg::OPM_IDLE_SLOW &&
                         slow_mode_q);
  assign wdt_clear = (state_q == opm_pkg::OPM_RUN) && halt_exec;
  // Only a watchdog wake resets PC and SP, on leaving the delay
  // It fires in the last wake cycle so the core restarts from the reset vector
  assign pc_sp_reset = (state_q == opm_pkg::OPM_WAKE) && wake_by_wdt_q &&
                       (wake_cnt_q >= wake_len - 11'h001) &&
                       (slow_mode_q || fast_stable);

  // ***************************************************************
  // Status flags
  // ***************************************************************
  // The timeout flag is only set by an overflow while powered down; an
  // overflow while running is a full reset, handled outside this block.
  // Halt wins over a clear-watchdog in the same cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      power_down_flag <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
    end else begin
      if (state_q == opm_pkg::OPM_RUN && halt_exec) begin
        power_down_flag <= 1'b1;
      end else if (clr_wdt_exec) begin
        power_down_flag <= 1'b0;
      end
      if (halted && state_q != opm_pkg::OPM_WAKE && wake.wdt_ovf) begin
        watchdog_timeout_flag <= 1'b1;
      end else if (state_q == opm_pkg::OPM_RUN && halt_exec) begin
        watchdog_timeout_flag <= 1'b0;
      end
    end
  end
endmodule // opm_ctrl

/* opm_pkg.sv */
// Summary of operation
// - Crystal enable clears stable flag, sets when stable
// - Crystal enable bit0 resets 0, flag read-only
// - Fast RC frequency change clears its stable flag
// - Fast RC enable bit0 resets to 1
// - Unused oscillator control bits read zero
// - Select 111 moves to slow mode
// - Select 000-110 gives fast clock divided 1..64
// - Slow switch waits for slow RC stable
// - Fast return waits for oscillator restart
// - Halt with both keeps zero enters sleep
// - Keep slow only enters slow-only idle
// - Both keeps set enters both-clocks idle
// - Keep fast only enters fast-only idle
// - Halt entry sets power-down, clears timeout, watchdog
// - Powered-down state keeps memory, registers, ports
// - Fast-only idle keeps system-clock peripherals running; here only outside slow mode
// - Wake delay 1024 crystal, 16 RC, else 2
// - Wake on port pin fall, interrupt, watchdog
// - Watchdog wake sets timeout, resets PC/SP only
// - Power-down flag cleared by power-up, clear-watchdog
// - Select chooses fast, divisions, or slow clock
// - Port wake resumes after the halt
// - Fast wake waits for oscillator stable flag
package opm_pkg;
  // ***************************************************************
  // Register map (byte addresses on APB)
  // ***************************************************************
  localparam logic [11:0] OPM_ADDR_SYSCLK_CFG = 12'h000;
  localparam logic [11:0] OPM_ADDR_XTAL_CTRL = 12'h004;
  localparam logic [11:0] OPM_ADDR_FRC_CTRL = 12'h008;
  localparam logic [11:0] OPM_ADDR_FRC_TRIM = 12'h00c;
  localparam logic [11:0] OPM_ADDR_STATUS = 12'h010;
  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int OPM_BIT_EN = 0;
  localparam int OPM_BIT_STABLE = 1;
  localparam int OPM_BIT_KEEP_SLOW = 0;
  localparam int OPM_BIT_KEEP_FAST = 1;
  localparam int OPM_BIT_FAST_SRC = 3;
  localparam int OPM_POS_SEL = 5;
  // ***************************************************************
  // Reset values and counts
  // ***************************************************************
  localparam logic [2:0] OPM_SEL_RST = 3'h0;
  localparam logic [2:0] OPM_SEL_SLOW = 3'h7;
  localparam logic OPM_XTAL_EN_RST = 1'b0;
  localparam logic OPM_FRC_EN_RST = 1'b1;
  localparam logic [7:0] OPM_TRIM_RST = 8'h00;
  localparam int OPM_XTAL_WAKE_CYC = 1024;
  localparam int OPM_FRC_WAKE_CYC = 16;
  localparam int OPM_RUN_WAKE_CYC = 2;
  localparam int OPM_SLOW_START_CYC = 2;

  typedef enum logic [2:0] {
    OPM_RUN = 3'b000,
    OPM_SLEEP = 3'b001,
    OPM_IDLE_SLOW = 3'b010,
    OPM_IDLE_BOTH = 3'b011,
    OPM_IDLE_FAST = 3'b100,
    OPM_WAKE = 3'b101
  } opm_state_t;

  typedef struct packed {
    logic port_fall;
    logic irq;
    logic wdt_ovf;
  } opm_wake_t;
endpackage : opm_pkg

/* opm_ctrl_properties.sv */
// ****************************************
// Mode and register checks
// ****************************************
module opm_ctrl_properties #(
  parameter int XTAL_WAKE_CYC = opm_pkg::OPM_XTAL_WAKE_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic wdt_overflow,
  input wire logic slow_rc_ready,
  input wire logic cpu_stall,
  input wire logic wdt_clear,
  input wire logic fast_clk_on,
  input wire logic sys_clk_gate,
  input wire logic sys_clk_is_slow,
  input wire logic [6:0] sys_clk_div,
  input wire logic power_down_flag,
  input wire logic watchdog_timeout_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic acc;
  logic [7:0] cfg_q;
  // Shadow of the config word, so halt checks know the keep bits
  assign acc = psel && penable;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= 8'h00;
    end else if (acc && pwrite && paddr == opm_pkg::OPM_ADDR_SYSCLK_CFG) begin
      cfg_q <= pwdata[7:0];
    end
  end
  // Halt only counts when the core is running
  sequence halt_taken;
    halt_exec && !cpu_stall;
  endsequence
  sequence fast_sel_written;
    acc && pwrite && paddr == opm_pkg::OPM_ADDR_SYSCLK_CFG ##1 cfg_q[7:5] != 3'h7;
  endsequence
  halt_flags_a: assert property (halt_taken |=> cpu_stall && power_down_flag && !watchdog_timeout_flag)
    else $error("halt entry flags wrong");
  wdt_clear_a: assert property (halt_taken |-> ##[0:1] wdt_clear)
    else $error("no watchdog clear on halt");
  sleep_clocks_a: assert property (halt_taken ##0 cfg_q[1:0] == 2'b00
    |=> !fast_clk_on && !sys_clk_gate) else $error("clocks run in sleep");
  keep_fast_a: assert property (halt_taken |=> fast_clk_on == $past(cfg_q[1]))
    else $error("fast clock keep bit ignored");
  sel_map_a: assert property (fast_sel_written |-> ##[0:60]
    (sys_clk_div == 7'(7'h01 << cfg_q[7:5]) && !sys_clk_is_slow)) else $error("divider wrong");
  slow_sw_a: assert property ($rose(slow_rc_ready) && cfg_q[7:5] == 3'h7 |-> ##[0:20] sys_clk_is_slow)
    else $error("slow switch missing");
  slow_wait_a: assert property (!slow_rc_ready ##1 !slow_rc_ready && !sys_clk_is_slow
    |=> !sys_clk_is_slow) else $error("slow switch before ready");
  div_onehot_a: assert property ($onehot(sys_clk_div))
    else $error("divider not one-hot");
  upper_zero_a: assert property (acc && !pwrite && (paddr == opm_pkg::OPM_ADDR_XTAL_CTRL
    || paddr == opm_pkg::OPM_ADDR_FRC_CTRL) |-> prdata[31:2] == 30'h0) else $error("upper bits set");
  wdt_wake_a: assert property ($rose(wdt_overflow) && cpu_stall |-> ##[1:8] watchdog_timeout_flag)
    else $error("timeout flag not set");
  pdf_clear_a: assert property (clr_wdt_exec && !halt_exec |=> !power_down_flag)
    else $error("power-down flag not cleared");
endmodule // opm_ctrl_properties

/* opm_ctrl_tb.sv */
// ****************************************
// Bench for the oscillator and mode block
// ****************************************
module opm_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int XW = 16;
  localparam logic [11:0] a_cf = opm_pkg::OPM_ADDR_SYSCLK_CFG;
  localparam logic [11:0] a_xt = opm_pkg::OPM_ADDR_XTAL_CTRL;
  localparam logic [11:0] a_fr = opm_pkg::OPM_ADDR_FRC_CTRL;
  localparam logic [11:0] a_tr = opm_pkg::OPM_ADDR_FRC_TRIM;
  localparam logic [11:0] a_st = opm_pkg::OPM_ADDR_STATUS;
  logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic halt_exec = 1'b0, clr_wdt_exec = 1'b0, sys_irq = 1'b0, wdt_overflow = 1'b0;
  logic slow_rc_ready = 1'b0;
  logic [7:0] port_a_pin = 8'hff, port_a_wake_en = 8'h01;
  logic pready, pslverr, cpu_stall, pc_sp_reset, wdt_clear, fast_clk_on, slow_clk_on;
  logic sys_clk_gate, sys_clk_is_slow, xtal_osc_run, frc_osc_run, power_down_flag;
  logic watchdog_timeout_flag, rerr;
  logic [6:0] sys_clk_div, exp7;
  logic [7:0] frc_trim;
  logic [31:0] prdata, rdata;
  int fail_count = 0, n_tests = 0, pcsp_n = 0, i, n;

  // Free-running core clock
  always #12.5 mclk = ~mclk;

  opm_ctrl #(.XTAL_WAKE_CYC(XW)) u_dut (
    .mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .halt_exec, .clr_wdt_exec, .port_a_pin, .port_a_wake_en, .sys_irq, .wdt_overflow,
    .slow_rc_ready, .cpu_stall, .pc_sp_reset, .wdt_clear, .fast_clk_on, .slow_clk_on,
    .sys_clk_gate, .sys_clk_is_slow, .sys_clk_div, .xtal_osc_run, .frc_osc_run, .frc_trim,
    .power_down_flag, .watchdog_timeout_flag
  );

  // Restart pulses are counted mid-cycle, where the output has settled
  always @(negedge mclk) begin
    if (pc_sp_reset === 1'b1) pcsp_n++;
  end

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the edge that sees pready
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) fail_count++;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  // Halt with config c, wake by source src, expect the wake span in [lo, hi]
  task automatic nap(input logic [7:0] c, input int src, input int lo, input int hi);
    int k;
    pcsp_n = 0;
    bus(1'b1, a_cf, {24'h0, c});
    halt_exec <= 1'b1;
    @(posedge mclk);
    halt_exec <= 1'b0;
    @(negedge mclk);
    chk({cpu_stall, power_down_flag, watchdog_timeout_flag}, 3'b110);
    chk({fast_clk_on, sys_clk_gate}, {c[1], c[1]});
    chk(frc_trim, 8'h55);
    chk({xtal_osc_run, frc_osc_run, slow_clk_on}, {c[1], c[1], c[0] | !c[1]});
    @(posedge mclk);
    sys_irq <= src == 0;
    wdt_overflow <= src == 1;
    port_a_pin <= src == 2 ? 8'hfe : 8'hff;
    for (k = 0; k < 200 && cpu_stall !== 1'b0; k++) @(negedge mclk);
    chk(k >= lo && k <= hi, 1'b1);
    chk({watchdog_timeout_flag, power_down_flag}, {src == 1, 1'b1});
    @(posedge mclk);
    sys_irq <= 1'b0;
    wdt_overflow <= 1'b0;
    port_a_pin <= 8'hff;
    clr_wdt_exec <= 1'b1;
    @(posedge mclk);
    clr_wdt_exec <= 1'b0;
    @(negedge mclk);
    chk(power_down_flag, 1'b0);
    chk(pcsp_n, src == 1);
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (6000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk(a_xt, 32'h0);
    rchk(a_cf, 32'h0);
    rchk(a_st, 32'h0);
    bus(1'b0, a_fr, 32'h0);
    chk(rdata[0], 1'b1);
    bus(1'b0, 12'h014, 32'h0);
    chk({rerr, rdata[7:0]}, 9'h100);
    bus(1'b1, a_xt, 32'hffff_fffe);
    rchk(a_xt, 32'h0);
    bus(1'b1, a_xt, 32'h1);
    rchk(a_xt, 32'h1);
    for (n = 0; n < 99 && rdata[1] !== 1'b1; n++) bus(1'b0, a_xt, 32'h0);
    chk(rdata, 32'h3);
    chk(3 * n + 3 >= XW, 1'b1);
    bus(1'b1, a_fr, 32'hffff_fffd);
    bus(1'b0, a_fr, 32'h0);
    chk(rdata & 32'hffff_fffd, 32'h1);
    bus(1'b1, a_tr, 32'h55);
    rchk(a_fr, 32'h1);
    for (n = 0; n < 99 && rdata[1] !== 1'b1; n++) bus(1'b0, a_fr, 32'h0);
    chk(rdata, 32'h3);
    // Walk every fast divisor
    for (i = 0; i < 7; i++) begin
      bus(1'b1, a_cf, 32'(i) << 5);
      exp7 = 7'h01 << i;
      @(negedge mclk);
      for (n = 0; n < 60 && sys_clk_div !== exp7; n++) @(negedge mclk);
      chk(sys_clk_div, exp7);
    end
    // Slow switch holds until the slow source reports ready
    bus(1'b1, a_cf, 32'he0);
    repeat (20) @(negedge mclk);
    chk(sys_clk_is_slow, 1'b0);
    @(posedge mclk);
    slow_rc_ready <= 1'b1;
    for (n = 0; n < 40 && sys_clk_is_slow !== 1'b1; n++) @(negedge mclk);
    rchk(a_st, 32'h4);
    // Return to fast with the fast source stopped meanwhile
    bus(1'b1, a_fr, 32'h0);
    bus(1'b1, a_cf, 32'h0);
    repeat (12) @(negedge mclk);
    chk(sys_clk_is_slow, 1'b1);
    bus(1'b1, a_fr, 32'h1);
    for (n = 0; n < 60 && sys_clk_is_slow !== 1'b0; n++) @(negedge mclk);
    rchk(a_fr, 32'h3);
    rchk(a_st, 32'h0);
    for (i = 0; i < 4; i++) nap(i[7:0], 0, i > 1 ? 2 : 16, i > 1 ? 10 : 45);
    nap(8'h00, 1, 16, 45);
    nap(8'h00, 2, 16, 45);
    bus(1'b1, a_cf, 32'h8);
    repeat (20) @(negedge mclk);
    nap(8'h08, 0, XW, 60);
    wrap_up();
  end
endmodule // opm_ctrl_tb

bind opm_ctrl opm_ctrl_properties #(.XTAL_WAKE_CYC(XTAL_WAKE_CYC)) u_props (
  .mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .halt_exec,
  .clr_wdt_exec, .wdt_overflow, .slow_rc_ready, .cpu_stall, .wdt_clear, .fast_clk_on,
  .sys_clk_gate, .sys_clk_is_slow, .sys_clk_div, .power_down_flag, .watchdog_timeout_flag
);
